// ==== sfoc_cfg.svh ====
/*
  Constants of the sync filter and output control block: register indices,
  reset values, field positions and timing counts.
  Assumes inclusion by bare name from the top module and the checker only.
*/
`ifndef SFOC_CFG_SVH
`define SFOC_CFG_SVH

// ----------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define SFOC_IDX_WINDOW 8'h20
`define SFOC_IDX_FILT 8'h21
`define SFOC_IDX_VWIDTH 8'h22
`define SFOC_IDX_HWIDTH 8'h23
`define SFOC_IDX_POL 8'h24
`define SFOC_IDX_SRC 8'h30
`define SFOC_IDX_STAT 8'h31

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define SFOC_RST_WINDOW 8'h0A
`define SFOC_RST_FILT 8'h80
`define SFOC_RST_VWIDTH 8'h04
`define SFOC_RST_HWIDTH 8'h20
`define SFOC_RST_POL 8'hFE
`define SFOC_RST_SRC 8'h00

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define SFOC_B_PROC_FILT 7
`define SFOC_B_PLL_FILT 6
`define SFOC_B_VFILT_EN 5
`define SFOC_B_VDUR_EN 4
`define SFOC_B_MEAS_MODE 3
`define SFOC_B_MEAS_LEN 2
`define SFOC_B_HS_POL 7
`define SFOC_B_VS_POL 6
`define SFOC_B_DISP_EN_POL 5
`define SFOC_B_FLD_POL 4
`define SFOC_B_CSYNC_POL 3
`define SFOC_B_SRC_GREEN 0

// ----------------------------------------------------------------------
// Timing counts in pixel clocks or lines
// ----------------------------------------------------------------------
`define SFOC_VS_MIN_LINES 12'h040
`define SFOC_SEP_THRESH 12'h008
`define SFOC_DLY_SHORT 5'h0A
`define SFOC_DLY_LONG 5'h10
`define SFOC_MEAS_SPAN 5'h06

`endif

// ==== sfoc_pkg.sv ====
/*
  Types of the sync filter and output control block.
  Needs no other file; the constants header is not included here.
*/
package sfoc_pkg;

  // ----------------------------------------------------------------------
  // Sync inputs, all active high, synchronous to the pixel clock
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic hsync_raw;
    logic sync_on_green_input;
    logic vsync_raw;
    logic disp_en_src;
    logic pll_fb;
    logic clamp;
    logic ref_tick;
  } sfoc_sync_in_t;

  // ----------------------------------------------------------------------
  // Formatted outputs; polarity applied to the first five only
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic hsync;
    logic vsync;
    logic display_enable_out;
    logic field;
    logic composite_sync_out_pin;
    logic pll_ref;
    logic proc_hsync;
    logic auto_offset_measure;
  } sfoc_sync_out_t;

  // Vertical filter states, Gray coded along idle-arm-mid-pulse
  typedef enum logic [1:0] {
    SFOC_V_IDLE = 2'b00,
    SFOC_V_ARM = 2'b01,
    SFOC_V_MID = 2'b11,
    SFOC_V_PULSE = 2'b10
  } sfoc_vstate_t;

endpackage

// ==== sfoc_top.sv ====
/*
  Sync processing and output sync formatting on the pixel clock: sync source
  selection, horizontal sync window filter, vertical sync filter with field
  detection, programmable output widths, auto-offset timing and polarity.
  Assumes an APB master, inputs synchronous to sys_clk_i, and a one-cycle
  40 MHz reference tick supplied with the sync inputs.
*/
// Local design decision: the APB slave port.
`include "sfoc_cfg.svh"

module sfoc_top (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire sfoc_pkg::sfoc_sync_in_t sync_i,
  output sfoc_pkg::sfoc_sync_out_t sync_o
);

  // Apply an active-high-when-set polarity bit
  function automatic logic pol(input logic lvl, input logic bitv);
    pol = bitv ? lvl : ~lvl;
  endfunction

  logic [7:0] win_q, filt_q, vwid_q, hwid_q, pol_q, src_q;
  logic [11:0] lpf_q;
  logic field_q;
  logic lock_q;

  // ----------------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------------
  logic setup;
  logic [7:0] idx;
  logic mapped;
  logic [31:0] rdata;
  assign setup = psel_i & ~penable_i;
  assign idx = paddr_i[9:2];

  // Read decode; reserved bits read as zero
  always_comb begin
    mapped = (paddr_i[11:10] == 2'h0) && (paddr_i[1:0] == 2'h0);
    rdata = 32'h0000_0000;
    case (idx)
      `SFOC_IDX_WINDOW: rdata[7:0] = win_q;
      `SFOC_IDX_FILT: rdata[7:0] = filt_q;
      `SFOC_IDX_VWIDTH: rdata[7:0] = vwid_q;
      `SFOC_IDX_HWIDTH: rdata[7:0] = hwid_q;
      `SFOC_IDX_POL: rdata[7:0] = pol_q;
      `SFOC_IDX_SRC: rdata[7:0] = src_q;
      `SFOC_IDX_STAT: rdata[13:0] = {lock_q, field_q, lpf_q};
      default: mapped = 1'b0;
    endcase
  end

  // Answer in the first access cycle; pready high for that cycle only
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
    end else begin
      pready_o <= setup;
      pslverr_o <= setup & ~mapped;
      if (setup) begin
        prdata_o <= (mapped && !pwrite_i) ? rdata : 32'h0000_0000;
      end
    end
  end

  // Writes take effect at the edge that completes the access
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      win_q <= `SFOC_RST_WINDOW;
      filt_q <= `SFOC_RST_FILT;
      vwid_q <= `SFOC_RST_VWIDTH;
      hwid_q <= `SFOC_RST_HWIDTH;
      pol_q <= `SFOC_RST_POL;
      src_q <= `SFOC_RST_SRC;
    end else if (psel_i && penable_i && pready_o && pwrite_i && !pslverr_o) begin
      case (idx)
        `SFOC_IDX_WINDOW: win_q <= pwdata_i[7:0];
        `SFOC_IDX_FILT: filt_q <= pwdata_i[7:0];
        `SFOC_IDX_VWIDTH: vwid_q <= pwdata_i[7:0];
        `SFOC_IDX_HWIDTH: hwid_q <= pwdata_i[7:0];
        `SFOC_IDX_POL: pol_q <= pwdata_i[7:0];
        `SFOC_IDX_SRC: src_q <= pwdata_i[7:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Horizontal sync window filter
  // ----------------------------------------------------------------------
  logic raw_hs, raw_hs_q, raw_rise;
  logic [11:0] rcnt_q, per_q;
  logic acc_q;
  logic [12:0] lo_b, hi_b;
  assign raw_hs = src_q[`SFOC_B_SRC_GREEN] ? sync_i.sync_on_green_input : sync_i.hsync_raw;
  assign raw_rise = raw_hs & ~raw_hs_q;
  assign lo_b = {1'b0, per_q} - {5'h00, win_q};
  assign hi_b = {1'b0, per_q} + {5'h00, win_q};

  // Learn the period in reference ticks, gate edges outside the window
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      raw_hs_q <= 1'b0;
      rcnt_q <= 12'h000;
      per_q <= 12'h000;
      lock_q <= 1'b0;
      acc_q <= 1'b0;
    end else begin
      raw_hs_q <= raw_hs;
      if (sync_i.ref_tick && rcnt_q != 12'hFFF) begin
        rcnt_q <= rcnt_q + 12'h001;
      end
      if (raw_rise) begin
        if (!lock_q || ({1'b0, rcnt_q} >= lo_b && {1'b0, rcnt_q} <= hi_b)) begin
          acc_q <= 1'b1;
          per_q <= rcnt_q;
          rcnt_q <= 12'h000;
          lock_q <= 1'b1;
        end
      end else if (!raw_hs) begin
        acc_q <= 1'b0;
      end
      // Too long without an accepted edge: relearn from the next one
      if (lock_q && {1'b0, rcnt_q} > hi_b) begin
        lock_q <= 1'b0;
      end
    end
  end

  // Filtered sync also serves as the regenerated sync (no coasting here)
  logic filt_hs, proc_hs, proc_hs_q, hs_edge;
  assign filt_hs = raw_hs & (acc_q | (raw_rise & ~lock_q));
  assign proc_hs = filt_q[`SFOC_B_PROC_FILT] ? filt_hs : raw_hs;
  assign hs_edge = proc_hs & ~proc_hs_q;

  // ----------------------------------------------------------------------
  // Line timing and quadrant decode
  // ----------------------------------------------------------------------
  logic [11:0] pcnt_q, llen_q, pos;
  logic [13:0] pos4, len1, len3;
  logic quad_mid;

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      proc_hs_q <= 1'b0;
      pcnt_q <= 12'h000;
      llen_q <= 12'h000;
    end else begin
      proc_hs_q <= proc_hs;
      if (hs_edge) begin
        llen_q <= pcnt_q + 12'h001;
        pcnt_q <= 12'h000;
      end else if (pcnt_q != 12'hFFF) begin
        pcnt_q <= pcnt_q + 12'h001;
      end
    end
  end

  // Quadrant one opens at sync edge plus separator threshold
  always_comb begin
    pos = pcnt_q - `SFOC_SEP_THRESH;
    if (pcnt_q < `SFOC_SEP_THRESH) begin
      pos = pcnt_q + llen_q - `SFOC_SEP_THRESH;
    end
    pos4 = {pos, 2'b00};
    len1 = {2'b00, llen_q};
    len3 = {1'b0, llen_q, 1'b0} + {2'b00, llen_q};
    quad_mid = (pos4 >= len1) && (pos4 < len3);
  end

  // ----------------------------------------------------------------------
  // Vertical sync filter and duration
  // ----------------------------------------------------------------------
  sfoc_pkg::sfoc_vstate_t vst_q;
  logic vs_raw_q, vs_rise, vs_fall, vfield_q, vs_reg_q;
  logic [11:0] lines_q;
  logic [7:0] vdur_q;
  logic mid_hit;
  assign vs_rise = sync_i.vsync_raw & ~vs_raw_q;
  assign vs_fall = ~sync_i.vsync_raw & vs_raw_q;
  assign mid_hit = (pcnt_q == {1'b0, llen_q[11:1]});

  // Start the regenerated pulse at the next line edge, or mid-line for the mid-quadrant field, and time its width
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      vst_q <= sfoc_pkg::SFOC_V_IDLE;
      vs_raw_q <= 1'b0;
      vfield_q <= 1'b0;
      vs_reg_q <= 1'b0;
      lines_q <= 12'h000;
      vdur_q <= 8'h00;
    end else begin
      vs_raw_q <= sync_i.vsync_raw;
      if (hs_edge && lines_q != 12'hFFF) begin
        lines_q <= lines_q + 12'h001;
      end
      case (vst_q)
        sfoc_pkg::SFOC_V_IDLE: begin
          if (vs_rise && lines_q >= `SFOC_VS_MIN_LINES) begin
            vfield_q <= quad_mid;
            vst_q <= sfoc_pkg::SFOC_V_ARM;
          end
        end
        sfoc_pkg::SFOC_V_ARM: begin
          if (hs_edge) begin
            lines_q <= 12'h000;
            if (vfield_q) begin
              vst_q <= sfoc_pkg::SFOC_V_MID;
            end else begin
              vs_reg_q <= 1'b1;
              vdur_q <= 8'h00;
              vst_q <= sfoc_pkg::SFOC_V_PULSE;
            end
          end
        end
        sfoc_pkg::SFOC_V_MID: begin
          if (mid_hit) begin
            vs_reg_q <= 1'b1;
            vdur_q <= 8'h00;
            vst_q <= sfoc_pkg::SFOC_V_PULSE;
          end
        end
        sfoc_pkg::SFOC_V_PULSE: begin
          if (filt_q[`SFOC_B_VDUR_EN]) begin
            if (hs_edge) begin
              vdur_q <= vdur_q + 8'h01;
            end
            if ((hs_edge && vdur_q + 8'h01 >= vwid_q) || vwid_q == 8'h00) begin
              vs_reg_q <= 1'b0;
              vst_q <= sfoc_pkg::SFOC_V_IDLE;
            end
          end else if (!sync_i.vsync_raw) begin
            vs_reg_q <= 1'b0;
            vst_q <= sfoc_pkg::SFOC_V_IDLE;
          end
        end
        default: vst_q <= sfoc_pkg::SFOC_V_IDLE;
      endcase
    end
  end

  // Lines-per-frame snapshot and field, taken at the line edge after an accepted vertical edge
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      lpf_q <= 12'h000;
      field_q <= 1'b0;
    end else if (vst_q == sfoc_pkg::SFOC_V_ARM && hs_edge) begin
      lpf_q <= lines_q;
      field_q <= vfield_q;
    end else if (!filt_q[`SFOC_B_VFILT_EN] && vs_fall) begin
      field_q <= 1'b0;
    end
  end

  logic vs_int;
  assign vs_int = filt_q[`SFOC_B_VFILT_EN] ? vs_reg_q : sync_i.vsync_raw;

  // ----------------------------------------------------------------------
  // Horizontal output pulse
  // ----------------------------------------------------------------------
  logic fb_q, hs_out_q;
  logic [7:0] hcnt_q;

  // Starts on the feedback clock edge, ends after the programmed count
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      fb_q <= 1'b0;
      hs_out_q <= 1'b0;
      hcnt_q <= 8'h00;
    end else begin
      fb_q <= sync_i.pll_fb;
      if (sync_i.pll_fb && !fb_q && hwid_q != 8'h00) begin
        hs_out_q <= 1'b1;
        hcnt_q <= 8'h01;
      end else if (hs_out_q) begin
        if (hcnt_q >= hwid_q) begin
          hs_out_q <= 1'b0;
        end else begin
          hcnt_q <= hcnt_q + 8'h01;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Auto-offset measurement timing
  // ----------------------------------------------------------------------
  logic clamp_q, meas_wait_q, meas_on_q;
  logic [4:0] meas_cnt_q;
  logic [4:0] meas_delay;
  assign meas_delay = filt_q[`SFOC_B_MEAS_LEN] ? `SFOC_DLY_LONG : `SFOC_DLY_SHORT;

  // A new clamp restarts the window; overlapping windows are not queued
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      clamp_q <= 1'b0;
      meas_wait_q <= 1'b0;
      meas_on_q <= 1'b0;
      meas_cnt_q <= 5'h00;
    end else begin
      clamp_q <= sync_i.clamp;
      if (!filt_q[`SFOC_B_MEAS_MODE] && sync_i.clamp && !clamp_q) begin
        meas_on_q <= 1'b1;
        meas_wait_q <= 1'b0;
        meas_cnt_q <= 5'h01;
      end else if (filt_q[`SFOC_B_MEAS_MODE] && !sync_i.clamp && clamp_q) begin
        meas_wait_q <= 1'b1;
        meas_on_q <= 1'b0;
        meas_cnt_q <= 5'h01;
      end else if (meas_wait_q) begin
        if (meas_cnt_q >= meas_delay) begin
          meas_wait_q <= 1'b0;
          meas_on_q <= 1'b1;
          meas_cnt_q <= 5'h01;
        end else begin
          meas_cnt_q <= meas_cnt_q + 5'h01;
        end
      end else if (meas_on_q) begin
        if (meas_cnt_q >= `SFOC_MEAS_SPAN) begin
          meas_on_q <= 1'b0;
        end else begin
          meas_cnt_q <= meas_cnt_q + 5'h01;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Output formatting, every output from a flip-flop
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      sync_o <= '0;
    end else begin
      sync_o.hsync <= pol(hs_out_q, pol_q[`SFOC_B_HS_POL]);
      sync_o.vsync <= pol(vs_int, pol_q[`SFOC_B_VS_POL]);
      sync_o.display_enable_out <= pol(sync_i.disp_en_src, pol_q[`SFOC_B_DISP_EN_POL]);
      sync_o.field <= field_q ^ pol_q[`SFOC_B_FLD_POL];
      sync_o.composite_sync_out_pin <= pol(raw_hs, pol_q[`SFOC_B_CSYNC_POL]);
      sync_o.pll_ref <= filt_q[`SFOC_B_PLL_FILT] ? filt_hs : raw_hs;
      sync_o.proc_hsync <= proc_hs;
      sync_o.auto_offset_measure <= meas_on_q;
    end
  end

endmodule // sfoc_top

// ==== sfoc_props.sv ====
/*
  Port checker for the sync filter and output control block.
  Assumes it is bound to sfoc_top and sees only its ports.
*/
`include "sfoc_cfg.svh"
module sfoc_props (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire sfoc_pkg::sfoc_sync_in_t sync_i,
  input wire sfoc_pkg::sfoc_sync_out_t sync_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  // ----------------------------------------------------------------
  // Shadow registers
  // ----------------------------------------------------------------
  logic [7:0] idx, filt_q, hw_q, pol_q, pol_d1_q, src_q;
  logic ok_a, wr, raw, disp_en_x, csync_x, hs_act, hs_act_q, hw_chg_q;
  logic [8:0] hs_len_q;
  assign idx = paddr_i[9:2];
  assign ok_a = paddr_i[11:10] == 2'h0 && paddr_i[1:0] == 2'h0 && idx inside {`SFOC_IDX_WINDOW,
    `SFOC_IDX_FILT, `SFOC_IDX_VWIDTH, `SFOC_IDX_HWIDTH, `SFOC_IDX_POL, `SFOC_IDX_SRC,
    `SFOC_IDX_STAT};
  assign wr = psel_i && penable_i && pready_o && pwrite_i && !pslverr_o;
  assign raw = src_q[0] ? sync_i.sync_on_green_input : sync_i.hsync_raw;
  assign disp_en_x = sync_i.disp_en_src ~^ pol_q[5];
  assign csync_x = raw ~^ pol_q[3];
  assign hs_act = sync_o.hsync == pol_d1_q[7];
  // Mirror of writes; polarity delayed to match the output stage
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      filt_q <= `SFOC_RST_FILT;
      hw_q <= `SFOC_RST_HWIDTH;
      pol_q <= `SFOC_RST_POL;
      pol_d1_q <= `SFOC_RST_POL;
      src_q <= `SFOC_RST_SRC;
    end else begin
      pol_d1_q <= pol_q;
      if (wr && idx == `SFOC_IDX_FILT) filt_q <= pwdata_i[7:0];
      if (wr && idx == `SFOC_IDX_HWIDTH) hw_q <= pwdata_i[7:0];
      if (wr && idx == `SFOC_IDX_POL) pol_q <= pwdata_i[7:0];
      if (wr && idx == `SFOC_IDX_SRC) src_q <= pwdata_i[7:0];
    end
  end
  // Pulse length; runs cut by a width write are not judged
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      hs_act_q <= 1'b0;
      hs_len_q <= 9'h000;
      hw_chg_q <= 1'b0;
    end else begin
      hs_act_q <= hs_act;
      hs_len_q <= hs_act ? hs_len_q + 9'h001 : 9'h000;
      if (wr && idx == `SFOC_IDX_HWIDTH) hw_chg_q <= 1'b1;
      else if (hs_act && !hs_act_q) hw_chg_q <= 1'b0;
    end
  end
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_ready_next: assert property (psel_i && !penable_i |=> pready_o)
    else $error("no ready after setup");
  a_ready_pulse: assert property (pready_o |=> !pready_o)
    else $error("ready longer than one cycle");
  a_err_map: assert property (pready_o |-> pslverr_o == !ok_a)
    else $error("error flag wrong for address");
  a_pll_raw: assert property (!filt_q[6] |=> sync_o.pll_ref == $past(raw))
    else $error("pll reference not raw sync");
  a_proc_raw: assert property (!filt_q[7] |=> sync_o.proc_hsync == $past(raw))
    else $error("processing sync not raw sync");
  a_disp_en_pol: assert property (1'b1 |=> sync_o.display_enable_out == $past(disp_en_x))
    else $error("display enable polarity wrong");
  a_csync_pol: assert property (1'b1 |=> sync_o.composite_sync_out_pin == $past(csync_x))
    else $error("composite sync polarity wrong");
  a_hs_width: assert property (hs_act_q && !hs_act && !hw_chg_q |-> hs_len_q == {1'b0, hw_q})
    else $error("horizontal pulse width wrong");
  a_meas_clamp: assert property ($rose(sync_i.clamp) && !filt_q[3] |-> ##2
    sync_o.auto_offset_measure [*6] ##1 !sync_o.auto_offset_measure)
    else $error("measure window in clamp wrong");
  a_meas_delay: assert property ($fell(sync_i.clamp) && filt_q[3] && !filt_q[2] |->
    ##11 !sync_o.auto_offset_measure ##1 sync_o.auto_offset_measure)
    else $error("delayed measure start wrong");
  c_vsync: cover property ($rose(sync_o.vsync));
  c_err: cover property (pready_o && pslverr_o);
  c_meas_late: cover property ($rose(sync_o.auto_offset_measure) && filt_q[3]);
endmodule // sfoc_props

bind sfoc_top sfoc_props u_props (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
  .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .sync_i(sync_i),
  .sync_o(sync_o));

// ==== sfoc_src_model.sv ====
/*
  Sync source model: 64-cycle lines with sync, feedback, clamp and
  display enable, plus vertical sync at a requested line position.
  Assumes the same clock and reset as the block; all lines low when idle.
*/
module sfoc_src_model (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic run_i,
  input wire logic vs_go_i,
  input wire logic [5:0] vs_at_i,
  output sfoc_pkg::sfoc_sync_in_t sync_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] pos_q;
  logic arm_q;
  logic [7:0] vs_cnt_q;
  // Line position; stands still at zero between runs
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) pos_q <= 6'h00;
    else pos_q <= run_i ? pos_q + 6'h01 : 6'h00;
  end
  // Vertical pulse of three lines from the requested position
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      arm_q <= 1'b0;
      vs_cnt_q <= 8'h00;
    end else if (vs_go_i) begin
      arm_q <= 1'b1;
    end else if (arm_q && pos_q == vs_at_i) begin
      arm_q <= 1'b0;
      vs_cnt_q <= 8'hC0;
    end else if (vs_cnt_q != 8'h00) begin
      vs_cnt_q <= vs_cnt_q - 8'h01;
    end
  end
  // Line timing decoded from position
  always_comb begin
    sync_o.hsync_raw = run_i && pos_q < 6'h04;
    sync_o.sync_on_green_input = run_i && pos_q < 6'h06;
    sync_o.vsync_raw = vs_cnt_q != 8'h00;
    sync_o.disp_en_src = run_i && pos_q >= 6'h14 && pos_q < 6'h3C;
    sync_o.pll_fb = run_i && pos_q < 6'h02;
    sync_o.clamp = run_i && pos_q >= 6'h0A && pos_q < 6'h10;
    sync_o.ref_tick = run_i && pos_q[1:0] != 2'h3;
  end
endmodule // sfoc_src_model

// ==== tb_top.sv ====
/*
  Self-checking bench for sfoc_top: registers over APB, polarity,
  pulse widths, measure timing and the vertical filter.
  Assumes the sync source model and the bound checker.
*/
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, psel, pen, pwr, pready, pslverr, run, vs_go;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [5:0] vs_at;
  sfoc_pkg::sfoc_sync_in_t sin;
  sfoc_pkg::sfoc_sync_out_t sout;
  int fail_count = 0;
  int num_checks = 0;
  sfoc_top uut (.sys_clk_i(clk), .reset_i(rst), .psel_i(psel), .penable_i(pen),
    .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .sync_i(sin), .sync_o(sout));
  sfoc_src_model u_src (.clk_i(clk), .reset_i(rst), .run_i(run), .vs_go_i(vs_go),
    .vs_at_i(vs_at), .sync_o(sin));
  // 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic tally_and_finish;
    if (fail_count == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // Holds the request until ready is sampled high
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
    output logic [31:0] r, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    paddr <= a;
    pwr <= w;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(a, 1'b1, d, r, e);
  endtask
  function automatic logic pick(input int s);
    case (s)
      0: return sout.hsync;
      1: return sout.auto_offset_measure;
      2: return sout.vsync;
      default: return sin.clamp;
    endcase
  endfunction
  // Bounded waits: until high, and while high
  task automatic span(input int s, output int d);
    d = 0;
    while (pick(s) !== 1'b1 && d < 9000) begin
      @(posedge clk);
      d++;
    end
  endtask
  task automatic width(input int s, output int w);
    w = 0;
    while (pick(s) === 1'b1 && w < 9000) begin
      @(posedge clk);
      w++;
    end
  endtask
  task automatic vreq(input logic [5:0] at);
    vs_at <= at;
    vs_go <= 1'b1;
    @(posedge clk);
    vs_go <= 1'b0;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    logic [11:0] a[6] = '{12'h080, 12'h084, 12'h088, 12'h08C, 12'h090, 12'h0C0};
    logic [7:0] v[6] = '{8'h0A, 8'h80, 8'h04, 8'h20, 8'hFE, 8'h00};
    logic [31:0] r;
    logic e;
    for (int i = 0; i < 6; i++) begin
      apb(a[i], 1'b0, 32'h0, r, e);
      chk(r, {24'h0, v[i]});
    end
    wr(12'h088, 32'h00000002);
    apb(12'h088, 1'b0, 32'h0, r, e);
    chk(r, 32'h00000002);
    apb(12'h100, 1'b0, 32'h0, r, e);
    chk({r[30:0], e}, 32'h00000001);
    apb(12'h086, 1'b1, 32'h0, r, e);
    chk({31'h0, e}, 32'h00000001);
  endtask
  // Idle levels follow each polarity bit
  task automatic t_pol;
    wr(12'h090, 32'h00000000);
    repeat (3) @(posedge clk);
    chk({sout.hsync, sout.vsync, sout.display_enable_out, sout.field,
      sout.composite_sync_out_pin}, 32'h1D);
    wr(12'h090, 32'h000000FE);
    repeat (3) @(posedge clk);
    chk({sout.hsync, sout.vsync, sout.display_enable_out, sout.field,
      sout.composite_sync_out_pin}, 32'h02);
  endtask
  task automatic t_hs;
    int d, w;
    wr(12'h08C, 32'h00000005);
    width(0, w);
    span(0, d);
    width(0, w);
    chk(32'(w), 32'h5);
    wr(12'h08C, 32'h00000020);
    width(0, w);
    span(0, d);
    width(0, w);
    chk(32'(w), 32'h20);
  endtask
  // Measure window in clamp, then 10 and 16 cycles after it
  task automatic t_meas;
    logic [7:0] m[3] = '{8'h80, 8'h88, 8'h8C};
    int x[3] = '{2, 18, 24};
    int d, w;
    wr(12'h0C0, 32'h00000001);
    for (int i = 0; i < 3; i++) begin
      wr(12'h084, {24'h0, m[i]});
      width(3, w);
      span(3, d);
      span(1, d);
      width(1, w);
      chk(32'(d), 32'(x[i]));
      chk(32'(w), 32'h6);
    end
    wr(12'h0C0, 32'h00000000);
  endtask
  // Raw processing sync keeps quadrant positions exact
  task automatic t_vf;
    logic [31:0] r;
    logic e;
    logic seen;
    int d, w;
    wr(12'h084, 32'h00000030);
    repeat (4480) @(posedge clk);
    vreq(6'h0C);
    span(2, d);
    width(2, w);
    chk({31'h0, d < 150}, 32'h1);
    chk(32'(w), 32'h80);
    apb(12'h0C4, 1'b0, 32'h0, r, e);
    chk({31'h0, r[12]}, 32'h0);
    chk({31'h0, r[13]}, 32'h1);
    chk({31'h0, sout.field}, 32'h1);
    repeat (4480) @(posedge clk);
    vreq(6'h28);
    span(2, d);
    apb(12'h0C4, 1'b0, 32'h0, r, e);
    chk({31'h0, r[12]}, 32'h1);
    chk({31'h0, sout.field}, 32'h0);
    repeat (640) @(posedge clk);
    vreq(6'h0C);
    seen = 1'b0;
    repeat (300) begin
      @(posedge clk);
      if (sout.vsync === 1'b1) seen = 1'b1;
    end
    chk({31'h0, seen}, 32'h0);
    apb(12'h0C4, 1'b0, 32'h0, r, e);
    chk({31'h0, r[12]}, 32'h1);
  endtask
  // Main sequence
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    pen = 1'b0;
    pwr = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    run = 1'b0;
    vs_go = 1'b0;
    vs_at = 6'h00;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_pol();
    run <= 1'b1;
    t_hs();
    t_meas();
    t_vf();
    tally_and_finish();
  end
  // Watchdog, well beyond the expected run of about 10600 cycles
  initial begin
    repeat (40000) @(posedge clk);
    fail_count++;
    tally_and_finish();
  end
endmodule // tb_top
